// ### hw/arp_core.sv
/*
 * arp_core: accumulation, decimation shift, offset/gain trim, resolution cut and
 * window monitor for raw converter samples, with a register port and result FIFO.
 * assumes: samples come from logic on the same clock; software reads a result
 * word to pop it; reads answer one cycle after the strobe.
 */
module arp_core
    import arp_pkg::*;
#(
    parameter int FIFO_WORDS = FIFO_DEPTH
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // register port
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic [DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [DATA_W-1:0] o_reg_rdata,
    // raw sample stream
    input wire logic i_sample_valid,
    input wire logic [RAW_W-1:0] i_sample_data,
    output logic o_sample_ready,
    // status
    output logic o_window_match_flag,
    output logic o_result_ready_flag
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // mask of the significant bits at a resolution
    function automatic logic [RES_W-1:0] res_mask(input arp_res_t r);
        case (r)
            RES_16: res_mask = 16'hFFFF;
            RES_10: res_mask = 16'h03FF;
            RES_8: res_mask = 16'h00FF;
            default: res_mask = 16'h0FFF;
        endcase
    endfunction : res_mask

    // value at a resolution, extended to a signed compare width
    function automatic logic signed [RES_W:0] res_extend(input logic [RES_W-1:0] v,
            input arp_res_t r, input logic diff);
        logic [RES_W:0] m;
        logic [RES_W:0] x;
        m = {1'b0, res_mask(r)};
        x = {1'b0, v} & m;
        // sign bit sits at the top of the width
        if (diff && ((x & ~(m >> 1)) != '0)) begin
            x = x | ~m;
        end
        res_extend = signed'(x);
    endfunction : res_extend

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [SEL_W-1:0] sample_count_select_q;
    logic [ADJ_W-1:0] adjust_shift_q;
    logic differential_q;
    logic correction_on_q;
    arp_res_t resolution_select_q;
    arp_win_t window_compare_select_q;
    logic [RES_W-1:0] lower_threshold_q;
    logic [RES_W-1:0] upper_threshold_q;
    logic [TRIM_W-1:0] offset_trim_value_q;
    logic [TRIM_W-1:0] gain_trim_value_q;
    logic [FLAG_W-1:0] interrupt_flags_q;
    logic [DATA_W-1:0] rdata_q;

    logic wr_avg;
    logic wr_flags;
    logic pop;

    assign wr_avg = i_reg_wr && (i_reg_addr == OFS_AVG);
    assign wr_flags = i_reg_wr && (i_reg_addr == OFS_FLAGS);

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            sample_count_select_q <= '0;
            adjust_shift_q <= '0;
            differential_q <= 1'b0;
            correction_on_q <= 1'b0;
            resolution_select_q <= RES_12;
            window_compare_select_q <= WIN_OFF;
            lower_threshold_q <= '0;
            upper_threshold_q <= '0;
            offset_trim_value_q <= '0;
            gain_trim_value_q <= GAIN_RST;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                OFS_AVG: begin
                    // software picks the count and adjust pair
                    sample_count_select_q <= i_reg_wdata[AVG_SEL_LSB +: SEL_W];
                    adjust_shift_q <= i_reg_wdata[AVG_ADJ_LSB +: ADJ_W];
                end
                OFS_CTRL2: begin
                    differential_q <= i_reg_wdata[CTL_DIFF_BIT];
                    correction_on_q <= i_reg_wdata[CTL_CORR_BIT];
                    resolution_select_q <= arp_res_t'(i_reg_wdata[CTL_RES_LSB +: 2]);
                end
                OFS_WIN: window_compare_select_q <= arp_win_t'(i_reg_wdata[2:0]);
                OFS_LOWER: lower_threshold_q <= i_reg_wdata[RES_W-1:0];
                OFS_UPPER: upper_threshold_q <= i_reg_wdata[RES_W-1:0];
                OFS_OFFSET: offset_trim_value_q <= i_reg_wdata[TRIM_W-1:0];
                OFS_GAIN: gain_trim_value_q <= i_reg_wdata[TRIM_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // accumulation
    // ------------------------------------------------------------
    arp_state_t state_q;
    logic [ACC_W-1:0] acc_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_last;
    logic [SHIFT_W-1:0] auto_shift;
    logic [SHIFT_W-1:0] total_shift;
    logic [ACC_W-1:0] sum;
    logic take;
    logic done;

    // 2^sel samples, so sel = 2n gives 4^n; reserved codes take one
    assign cnt_last = (sample_count_select_q > SEL_MAX) ? '0
                      : CNT_W'((1 << sample_count_select_q) - 1);
    // automatic shift grows past sixteen samples, e.g. 512 gives 5
    assign auto_shift = (sample_count_select_q > AUTO_SHIFT_BASE &&
                         sample_count_select_q <= SEL_MAX)
                        ? sample_count_select_q - AUTO_SHIFT_BASE : '0;
    // total shift adds the adjust field
    assign total_shift = auto_shift + SHIFT_W'(adjust_shift_q);

    assign o_sample_ready = (state_q == ST_COLLECT);
    assign take = i_sample_valid && o_sample_ready;
    assign sum = acc_q + ACC_W'(i_sample_data);
    assign done = take && (cnt_q == cnt_last);

    // a new count setting restarts the running sum so no mixed batch escapes
    always_ff @(posedge i_ref_clk) begin
        if (i_srst || wr_avg) begin
            acc_q <= '0;
            cnt_q <= '0;
        end else if (done) begin
            acc_q <= '0;
            cnt_q <= '0;
        end else if (take) begin
            acc_q <= sum;
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // decimation and correction
    // ------------------------------------------------------------
    logic [RES_W-1:0] avg_res;
    logic signed [RES_W+1:0] off_diff;
    logic signed [30:0] gain_prod;
    logic signed [30:0] gain_scaled;
    logic [RES_W-1:0] trimmed;
    logic [RES_W-1:0] limit;
    logic [RES_W-1:0] sat_res;
    logic [RES_W-1:0] final_res;

    assign avg_res = RES_W'(sum >> total_shift);
    assign limit = (resolution_select_q == RES_16) ? MAX_16 : MAX_12;

    assign off_diff = signed'({2'b00, avg_res})
                      - (RES_W + 2)'(signed'(offset_trim_value_q));
    // gain is a 1.11 factor on the offset-corrected value
    assign gain_prod = 31'(off_diff) * 31'(signed'({1'b0, gain_trim_value_q}));
    assign gain_scaled = gain_prod >>> GAIN_FRAC;

    always_comb begin
        trimmed = avg_res;
        // trim only while correction is on
        if (correction_on_q) begin
            if (gain_scaled < 0) begin
                trimmed = '0;
            end else if (gain_scaled > 31'(limit)) begin
                trimmed = limit;
            end else begin
                trimmed = RES_W'(gain_scaled);
            end
        end
        sat_res = (trimmed > limit) ? limit : trimmed;
        case (resolution_select_q)
            RES_10: final_res = sat_res >> 2;
            RES_8: final_res = sat_res >> 4;
            default: final_res = sat_res;
        endcase
    end

    // ------------------------------------------------------------
    // window monitor
    // ------------------------------------------------------------
    logic signed [RES_W:0] cmp_val;
    logic signed [RES_W:0] cmp_lo;
    logic signed [RES_W:0] cmp_hi;
    logic win_hit;

    // thresholds cut to the resolution width
    assign cmp_val = res_extend(final_res, resolution_select_q, differential_q);
    assign cmp_lo = res_extend(lower_threshold_q, resolution_select_q, differential_q);
    assign cmp_hi = res_extend(upper_threshold_q, resolution_select_q, differential_q);

    always_comb begin
        case (window_compare_select_q)
            WIN_ABOVE: win_hit = cmp_val > cmp_lo;
            WIN_BELOW: win_hit = cmp_val < cmp_hi;
            WIN_INSIDE: win_hit = (cmp_val > cmp_lo) && (cmp_val < cmp_hi);
            WIN_OUTSIDE: win_hit = (cmp_val < cmp_lo) || (cmp_val > cmp_hi);
            default: win_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // hold stage and result buffer
    // ------------------------------------------------------------
    logic [RES_W-1:0] hold_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [RES_W-1:0] fifo_out_data;
    logic [$clog2(FIFO_WORDS):0] fifo_level;
    logic push;
    logic win_set;

    assign push = (state_q == ST_HOLD) && fifo_in_ready;
    assign win_set = done && win_hit;

    // a full buffer keeps the finished word here and stalls the sample source
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state_q <= ST_COLLECT;
        end else begin
            case (state_q)
                ST_COLLECT: state_q <= done ? ST_HOLD : ST_COLLECT;
                ST_HOLD: state_q <= push ? ST_COLLECT : ST_HOLD;
                default: state_q <= ST_COLLECT;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            hold_q <= '0;
        end else if (done) begin
            hold_q <= final_res;
        end
    end

    arp_fifo #(
        .WIDTH(RES_W),
        .DEPTH(FIFO_WORDS)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_in_valid(state_q == ST_HOLD),
        .i_in_data(hold_q),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(fifo_out_valid),
        .o_out_data(fifo_out_data),
        .i_out_ready(pop),
        .o_level(fifo_level)
    );

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    // set wins over a write-one clear in the same cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            interrupt_flags_q <= '0;
        end else begin
            interrupt_flags_q[FLG_WIN_BIT] <= win_set || (interrupt_flags_q[FLG_WIN_BIT]
                && !(wr_flags && i_reg_wdata[FLG_WIN_BIT]));
            interrupt_flags_q[FLG_READY_BIT] <= push || (interrupt_flags_q[FLG_READY_BIT]
                && !(wr_flags && i_reg_wdata[FLG_READY_BIT]));
        end
    end

    assign o_window_match_flag = interrupt_flags_q[FLG_WIN_BIT];
    assign o_result_ready_flag = interrupt_flags_q[FLG_READY_BIT];

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // popping on the strobe means a result word is consumed even if unused
    assign pop = i_reg_rd && (i_reg_addr == OFS_RESULT) && fifo_out_valid;

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            rdata_q <= '0;
        end else if (i_reg_rd) begin
            rdata_q <= '0;
            case (i_reg_addr)
                OFS_AVG: begin
                    rdata_q[AVG_SEL_LSB +: SEL_W] <= sample_count_select_q;
                    rdata_q[AVG_ADJ_LSB +: ADJ_W] <= adjust_shift_q;
                end
                OFS_CTRL2: begin
                    rdata_q[CTL_DIFF_BIT] <= differential_q;
                    rdata_q[CTL_CORR_BIT] <= correction_on_q;
                    rdata_q[CTL_RES_LSB +: 2] <= resolution_select_q;
                end
                OFS_WIN: rdata_q[2:0] <= window_compare_select_q;
                OFS_LOWER: rdata_q[RES_W-1:0] <= lower_threshold_q;
                OFS_UPPER: rdata_q[RES_W-1:0] <= upper_threshold_q;
                OFS_OFFSET: rdata_q[TRIM_W-1:0] <= offset_trim_value_q;
                OFS_GAIN: rdata_q[TRIM_W-1:0] <= gain_trim_value_q;
                OFS_FLAGS: rdata_q[FLAG_W-1:0] <= interrupt_flags_q;
                OFS_RESULT: rdata_q[RES_W-1:0] <= fifo_out_valid ? fifo_out_data : '0;
                OFS_STATUS: begin
                    rdata_q[STS_LEVEL_LSB +: $clog2(FIFO_WORDS) + 1] <= fifo_level;
                    rdata_q[STS_BUSY_BIT] <= (cnt_q != '0) || (state_q == ST_HOLD);
                end
                default: begin
                end
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign o_reg_rdata = rdata_q;

endmodule : arp_core

// ### hw/arp_pkg.sv
/*
 * arp_pkg: shared constants and types of the converter result post-processing block.
 * assumes: one 10 MHz clock, registers reached over a plain strobe port with 32-bit words.
 */
package arp_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int RAW_W = 12;
    localparam int ACC_W = 22;
    localparam int RES_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int SEL_W = 4;
    localparam int ADJ_W = 3;
    localparam int SHIFT_W = 4;
    localparam int CNT_W = 11;
    localparam int TRIM_W = 12;
    localparam int GAIN_FRAC = 11;
    localparam int FLAG_W = 2;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_AVG = 8'h00;
    localparam logic [7:0] OFS_CTRL2 = 8'h04;
    localparam logic [7:0] OFS_WIN = 8'h08;
    localparam logic [7:0] OFS_LOWER = 8'h0C;
    localparam logic [7:0] OFS_UPPER = 8'h10;
    localparam logic [7:0] OFS_OFFSET = 8'h14;
    localparam logic [7:0] OFS_GAIN = 8'h18;
    localparam logic [7:0] OFS_FLAGS = 8'h1C;
    localparam logic [7:0] OFS_RESULT = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int AVG_SEL_LSB = 0;
    localparam int AVG_ADJ_LSB = 4;
    localparam int CTL_DIFF_BIT = 0;
    localparam int CTL_CORR_BIT = 1;
    localparam int CTL_RES_LSB = 4;
    localparam int FLG_READY_BIT = 0;
    localparam int FLG_WIN_BIT = 1;
    localparam int STS_LEVEL_LSB = 0;
    localparam int STS_BUSY_BIT = 8;

    // ------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------
    localparam logic [TRIM_W-1:0] GAIN_RST = 12'h800;
    localparam logic [SEL_W-1:0] SEL_MAX = 4'hA;
    localparam logic [SEL_W-1:0] AUTO_SHIFT_BASE = 4'h4;
    localparam logic [RES_W-1:0] MAX_16 = 16'hFFFF;
    localparam logic [RES_W-1:0] MAX_12 = 16'h0FFF;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RES_12 = 2'h0,
        RES_16 = 2'h1,
        RES_10 = 2'h2,
        RES_8 = 2'h3
    } arp_res_t;

    typedef enum logic [2:0] {
        WIN_OFF = 3'h0,
        WIN_ABOVE = 3'h1,
        WIN_BELOW = 3'h2,
        WIN_INSIDE = 3'h3,
        WIN_OUTSIDE = 3'h4
    } arp_win_t;

    typedef enum logic {
        ST_COLLECT = 1'b0,
        ST_HOLD = 1'b1
    } arp_state_t;

endpackage : arp_pkg

// ### hw/arp_fifo.sv
/*
 * arp_fifo: result buffer with valid/ready on both sides and registered head data.
 * assumes: single clock, synchronous active-high reset, depth a power of two.
 */
module arp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready,
    // fill level
    output logic [$clog2(DEPTH):0] o_level
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [PW-1:0] rd_ptr_d;
    logic [PW:0] count_q;
    logic [PW:0] count_d;
    logic do_wr;
    logic do_rd;

    assign o_in_ready = (count_q < (PW + 1)'(DEPTH));
    assign do_wr = i_in_valid && o_in_ready;
    assign do_rd = o_out_valid && i_out_ready;
    assign rd_ptr_d = do_rd ? rd_ptr_q + 1'b1 : rd_ptr_q;
    assign count_d = count_q + (PW + 1)'(do_wr) - (PW + 1)'(do_rd);
    assign o_level = count_q;

    always_ff @(posedge i_ref_clk) begin
        if (do_wr) begin
            mem_q[wr_ptr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            wr_ptr_q <= do_wr ? wr_ptr_q + 1'b1 : wr_ptr_q;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
        end
    end

    // head register; a write landing on the next head is forwarded
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_out_valid <= 1'b0;
            o_out_data <= '0;
        end else begin
            o_out_valid <= (count_d != '0);
            o_out_data <= (do_wr && (wr_ptr_q == rd_ptr_d)) ? i_in_data : mem_q[rd_ptr_d];
        end
    end

endmodule : arp_fifo

// ### bench/arp_props.sv
/* arp_props: port-level checks of arp_core, attached by bind.
   assumes: one clock, synchronous active-high reset, no strobes during reset. */
module arp_props
    import arp_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // register port
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic [DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [DATA_W-1:0] o_reg_rdata,
    // samples and status
    input wire logic i_sample_valid,
    input wire logic o_sample_ready,
    input wire logic o_window_match_flag,
    input wire logic o_result_ready_flag
);
    // shadow of the averaging field, so batch length is known at the ports
    logic [6:0] avg_q;
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            avg_q <= 7'h00;
        end else if (i_reg_wr && i_reg_addr == OFS_AVG) begin
            avg_q <= i_reg_wdata[6:0];
        end
    end
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);
    sequence s_take_one;
        avg_q[3:0] == 4'h0 && i_sample_valid && o_sample_ready;
    endsequence
    sequence s_win_clear;
        i_reg_wr && i_reg_addr == OFS_FLAGS && i_reg_wdata[FLG_WIN_BIT];
    endsequence
    a_reset_clear: assert property ($past(i_srst) |-> o_reg_rdata == '0 && o_sample_ready && !o_window_match_flag && !o_result_ready_flag)
        else $error("state not cleared by reset");
    a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == '0)
        else $error("read data outside the answer cycle");
    a_unmapped_zero: assert property (i_reg_rd && i_reg_addr == 8'h28 |=> o_reg_rdata == '0)
        else $error("unmapped read not zero");
    a_avg_readback: assert property (i_reg_rd && i_reg_addr == OFS_AVG |=> o_reg_rdata == {25'h0, avg_q})
        else $error("averaging field readback wrong");
    a_batch_stall: assert property (s_take_one |=> !o_sample_ready)
        else $error("single-sample batch not held");
    a_ready_flag_soon: assert property (s_take_one |-> ##[1:4] o_result_ready_flag)
        else $error("result ready flag late");
    a_flag_clear: assert property (s_win_clear ##0 !(i_sample_valid && o_sample_ready) |=> !o_window_match_flag)
        else $error("window flag not cleared");
    a_flag_sticky: assert property (o_window_match_flag && !(i_reg_wr && i_reg_addr == OFS_FLAGS) |=> o_window_match_flag)
        else $error("window flag dropped by itself");
endmodule : arp_props

bind arp_core arp_props i_arp_props (
    .i_ref_clk, .i_srst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .i_sample_valid, .o_sample_ready, .o_window_match_flag, .o_result_ready_flag
);

// ### bench/arp_adc_model.sv
/* arp_adc_model: raw sample source in place of the converter core.
   assumes: a sample is taken on the rising edge with valid and ready high. */
module arp_adc_model
    import arp_pkg::*;
(
    // clock
    input wire logic i_ref_clk,
    // sample stream
    input wire logic i_sample_ready,
    output logic o_sample_valid,
    output logic [RAW_W-1:0] o_sample_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_sample_valid = 1'b0;
        o_sample_data = 12'hFFF;
    end
    // n copies of v; gap idle cycles after each model a slow core
    task automatic send(input logic [RAW_W-1:0] v, input int n, input int gap);
        @(posedge i_ref_clk);
        for (int k = 0; k < n; k++) begin
            o_sample_valid <= 1'b1;
            o_sample_data <= v;
            do @(posedge i_ref_clk); while (i_sample_ready !== 1'b1);
            if (gap > 0 || k == n - 1) begin
                o_sample_valid <= 1'b0;
                // released data never keeps the last value
                o_sample_data <= ~v;
                repeat (gap) @(posedge i_ref_clk);
            end
        end
    endtask : send
endmodule : arp_adc_model

// ### bench/tb.sv
/* tb: self-checking bench of arp_core fed by a raw sample source.
   assumes: arp_pkg compiled first; one 10 MHz clock. */
module tb
    import arp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic i_ref_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic s_valid;
    logic [11:0] s_data;
    logic s_ready;
    logic win_flag;
    logic res_flag;
    int mismatches = 0;
    int n_compared = 0;
    always #50 i_ref_clk = ~i_ref_clk;
    arp_core i_arp_core (
        .i_ref_clk, .i_srst, .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
        .i_reg_rd(rd), .o_reg_rdata(rdata), .i_sample_valid(s_valid),
        .i_sample_data(s_data), .o_sample_ready(s_ready),
        .o_window_match_flag(win_flag), .o_result_ready_flag(res_flag)
    );
    arp_adc_model i_arp_adc_model (
        .i_ref_clk, .i_sample_ready(s_ready), .o_sample_valid(s_valid), .o_sample_data(s_data)
    );
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_ref_clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic take(input logic [31:0] er);
        logic [31:0] d;
        repeat (60) if (res_flag !== 1'b1) @(posedge i_ref_clk) #1;
        check("result ready", res_flag, 32'h1);
        rd_reg(OFS_RESULT, d);
        check("result", d, er);
    endtask : take
    task automatic conv(input logic [31:0] ctl, win, lo, input logic [11:0] s,
            input logic [31:0] er, input logic ew);
        wr_reg(OFS_CTRL2, ctl);
        wr_reg(OFS_WIN, win);
        wr_reg(OFS_LOWER, lo);
        wr_reg(OFS_FLAGS, 32'h3);
        i_arp_adc_model.send(s, 1, 0);
        take(er);
        check("window flag", win_flag, ew);
    endtask : conv
    task automatic t_regs();
        logic [31:0] d;
        wr_reg(8'h28, 32'hFFFF);
        rd_reg(8'h28, d);
        check("unmapped", d, 32'h0);
        rd_reg(OFS_GAIN, d);
        check("gain reset", d, 32'h800);
        rd_reg(OFS_CTRL2, d);
        check("control reset", d, 32'h0);
        rd_reg(OFS_RESULT, d);
        check("empty result", d, 32'h0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_avg();
        logic [3:0] sel [5] = '{4'h2, 4'h4, 4'h6, 4'h8, 4'h9};
        logic [2:0] adj [5] = '{3'h1, 3'h2, 3'h1, 3'h0, 3'h4};
        logic [31:0] d;
        int sh;
        wr_reg(OFS_CTRL2, 32'h10);
        wr_reg(OFS_WIN, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr_reg(OFS_AVG, {25'h0, adj[i], sel[i]});
            rd_reg(OFS_AVG, d);
            check("avg field", d, {25'h0, adj[i], sel[i]});
            wr_reg(OFS_FLAGS, 32'h3);
            sh = (sel[i] > 4 ? sel[i] - 4 : 0) + adj[i];
            i_arp_adc_model.send(12'hFFF, 1 << sel[i], i % 2);
            take(((1 << sel[i]) * 32'hFFF) >> sh);
        end
        wr_reg(OFS_AVG, 32'h0);
        $display("test averaging done");
    endtask : t_avg
    task automatic t_window();
        logic [11:0] s;
        logic ew;
        wr_reg(OFS_UPPER, 32'h200);
        for (int m = 0; m < 5; m++) begin
            for (int j = 0; j < 3; j++) begin
                s = 12'(12'h080 + 12'h100 * j);
                case (m)
                    1: ew = s > 12'h100;
                    2: ew = s < 12'h200;
                    3: ew = s > 12'h100 && s < 12'h200;
                    4: ew = s < 12'h100 || s > 12'h200;
                    default: ew = 1'b0;
                endcase
                conv(32'h0, m, 32'h100, s, s, ew);
            end
        end
        conv(32'h31, 32'h1, 32'h0F0, 12'h100, 32'h10, 1'b1);
        conv(32'h31, 32'h1, 32'h0F0, 12'hE00, 32'hE0, 1'b0);
        conv(32'h30, 32'h1, 32'h1F0, 12'hF80, 32'hF8, 1'b1);
        conv(32'h30, 32'h1, 32'h0F0, 12'h100, 32'h10, 1'b0);
        conv(32'h20, 32'h2, 32'h0, 12'h400, 32'h100, 1'b1);
        $display("test window done");
    endtask : t_window
    task automatic t_correct();
        wr_reg(OFS_OFFSET, 32'h010);
        conv(32'h2, 32'h0, 32'h0, 12'h100, 32'h0F0, 1'b0);
        conv(32'h2, 32'h0, 32'h0, 12'h008, 32'h0, 1'b0);
        wr_reg(OFS_GAIN, 32'hC00);
        conv(32'h2, 32'h0, 32'h0, 12'h100, 32'h168, 1'b0);
        conv(32'h0, 32'h0, 32'h0, 12'h100, 32'h100, 1'b0);
        $display("test correction done");
    endtask : t_correct
    task automatic t_fifo();
        logic [31:0] d;
        // eight words fill the buffer, the ninth waits in the hold stage
        for (int k = 0; k < 9; k++) begin
            i_arp_adc_model.send(12'(12'h100 + k), 1, 0);
        end
        repeat (4) @(posedge i_ref_clk);
        #1 check("full refuses", s_ready, 32'h0);
        rd_reg(OFS_STATUS, d);
        check("level", d & 32'hF, 32'h8);
        for (int k = 0; k < 9; k++) begin
            rd_reg(OFS_RESULT, d);
            check("fifo order", d, 32'h100 + k);
        end
        $display("test fifo done");
    endtask : t_fifo
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    // about 1600 cycles are needed; cut off well past that
    initial begin
        #2_000_000;
        mismatches++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        t_regs();
        t_avg();
        t_window();
        t_correct();
        t_fifo();
        @(posedge i_ref_clk);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        t_regs();
        complete_run();
    end
endmodule : tb
